// ---- verilog/pwrsv_pkg.sv ----
/*
 * Shared constants, state codes and signal bundles for the power-saving controller.
 * Assumes a single 250 MHz system clock that is also the oscillator period for start-up timing.
 */
package pwrsv_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] DOZE_OFS = 12'h28C;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h290;
    localparam logic [ADDR_W-1:0] CFG_OFS = 12'h294;
    localparam int CTL_HALT = 7;
    localparam int CTL_SLOW = 6;
    localparam int CTL_WRS = 5;
    localparam int CTL_EXR = 4;
    localparam int RATIO_W = 3;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] CTL_MASK = 8'hF7;
    localparam int CFG_XTAL = 0;
    localparam int CFG_BOR = 1;
    localparam int CFG_LOWPOWER_BROWNOUT_RESET = 2;
    localparam int CFG_XCLR = 3;
    localparam int CFG_WDT = 4;
    localparam int CFG_WDT_SLP = 5;
    localparam logic [7:0] CFG_RST = 8'h0A;
    localparam logic [7:0] CFG_MASK = 8'h3F;
    localparam int Q_PHASES = 4;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam int CLK_PS = 4000;
    localparam int TOSC_PS = 4000;
    localparam int OST_TOSC = 1024;
    localparam int OST_CYC = (OST_TOSC * TOSC_PS + CLK_PS - 1) / CLK_PS;
    localparam int OST_W = $clog2(OST_CYC);
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_IDLE = 3'b010,
        ST_OST = 3'b011,
        ST_READY = 3'b100
    } pwrsv_state_t;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_IRQ = 2'h1;
    localparam logic [1:0] CAUSE_WINDOWED_WATCHDOG = 2'h2;
    typedef struct packed {
        logic sleep_exec;
        logic isr_request;
        logic isr_return;
        logic multicycle_busy;
        logic prefetch_clears_gate;
        logic global_interrupt_gate;
    } pwrsv_core_t;
    typedef struct packed {
        logic external_clear_pin;
        logic brownout_reset;
        logic lowpower_brownout_reset;
        logic por;
        logic windowed_watchdog;
    } pwrsv_rst_src_t;
endpackage

// ---- verilog/pwrsv_sync.sv ----
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is an independent slow level; no multi-bit coherence is kept.
 */
`timescale 1ns/10ps
module pwrsv_sync #(
    parameter int W = 1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_q <= '0;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule

// ---- verilog/pwrsv_doze.sv ----
/*
 * Doze cycle selector: marks one instruction cycle in every 2^(ratio+1).
 * Assumes i_step pulses once per instruction cycle while the CPU may run.
 */
`timescale 1ns/10ps
module pwrsv_doze #(
    parameter int RW = 3
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_step,
    input wire logic i_enable,
    input wire logic [RW-1:0] i_ratio,
    output logic o_hit
);
    localparam int CW = 1 << RW;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] last;

    // Ratio 000 is 1:2 and each code doubles the period.
    assign last = (CW'(2) << i_ratio) - CW'(1);
    assign o_hit = !i_enable || (cnt_reg == '0);

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_enable) begin
            cnt_reg <= '0;
        end else if (i_step) begin
            cnt_reg <= (cnt_reg >= last) ? '0 : cnt_reg + CW'(1);
        end
    end
endmodule

// ---- verilog/pwrsv_ctrl.sv ----
/*
 * Power-saving controller: doze throttling, Sleep and Idle entry and wake, status flags,
 * and an Avalon-MM register slave with waitrequest.
 * Assumes the core, interrupt controller and ready signals share i_clock; reset pins are async.
 */
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pwrsv_ctrl import pwrsv_pkg::*; #(
    parameter int NIRQ = 8,
    parameter int CLKSW_IDX = 3
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire pwrsv_core_t i_core,
    input wire logic [NIRQ-1:0] i_irq_flags,
    input wire logic [NIRQ-1:0] i_peripheral_irq_enable,
    input wire pwrsv_rst_src_t i_rst_pins,
    input wire logic i_program_flash_ready,
    input wire logic i_sysclk_ready,
    input wire logic i_bor_ready,
    output logic o_cpu_cycle_en,
    output logic o_periph_q_en,
    output logic o_vector_fetch,
    output logic o_exec_prefetch,
    output logic o_wdt_clear,
    output logic o_wdt_run,
    output logic o_device_reset,
    output logic o_cpu_clock_on,
    output logic o_fosc_on,
    output logic o_rc_osc_keep,
    output logic o_io_hold
);
    localparam logic [NIRQ-1:0] WAKE_MASK = ~(NIRQ'(1) << CLKSW_IDX);

    logic [7:0] ctl_reg;
    logic [7:0] cfg_reg;
    pwrsv_state_t state_reg;
    pwrsv_state_t state_next;
    logic pd_n_reg;
    logic to_n_reg;
    logic [1:0] cause_reg;
    logic [1:0] qph_reg;
    logic [OST_W-1:0] ost_reg;
    logic isr_pend_reg;
    logic wait_reg;
    logic [4:0] pins_s;
    pwrsv_rst_src_t rs;
    logic halt_select;
    logic slow_cpu_enable;
    logic wake_restores_speed;
    logic exit_reslows;
    logic doze_hit;
    logic in_run;
    logic q_end;
    logic fosc_run;
    logic wake_irq;
    logic sleep_nop;
    logic sleep_go;
    logic idle_go;
    logic irq_wake_slp;
    logic irq_wake_idl;
    logic windowed_watchdog_ev;
    logic windowed_watchdog_wake_idl;
    logic wdt_run_now;
    logic rst_hit;
    logic ready_ok;
    logic cpu_go;
    logic take;
    logic slow_clr;
    logic slow_set;
    logic wr_go;

    pwrsv_sync #(.W(5)) u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_d(i_rst_pins),
        .o_q(pins_s)
    );
    assign rs = pwrsv_rst_src_t'(pins_s);

    assign halt_select = ctl_reg[CTL_HALT];
    assign slow_cpu_enable = ctl_reg[CTL_SLOW];
    assign wake_restores_speed = ctl_reg[CTL_WRS];
    assign exit_reslows = ctl_reg[CTL_EXR];

    pwrsv_doze #(.RW(RATIO_W)) u_doze (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_step(q_end && in_run),
        .i_enable(slow_cpu_enable),
        .i_ratio(ctl_reg[RATIO_W-1:0]),
        .o_hit(doze_hit)
    );

    assign in_run = (state_reg == ST_RUN);
    assign q_end = (qph_reg == Q_LAST);
    // The main oscillator, and with it Fosc, stops only in Sleep and its start-up.
    assign fosc_run = (state_reg != ST_SLEEP) && (state_reg != ST_OST);
    // The clock-switch source never wakes; the global gate is not consulted here.
    assign wake_irq = |(i_irq_flags & i_peripheral_irq_enable & WAKE_MASK);
    assign sleep_nop = wake_irq && !i_core.global_interrupt_gate;
    assign sleep_go = in_run && i_core.sleep_exec && !sleep_nop && !halt_select;
    assign idle_go = in_run && i_core.sleep_exec && !sleep_nop && halt_select;
    assign irq_wake_slp = (state_reg == ST_SLEEP) && wake_irq;
    assign irq_wake_idl = (state_reg == ST_IDLE) && wake_irq;
    assign wdt_run_now = cfg_reg[CFG_WDT] && (fosc_run || cfg_reg[CFG_WDT_SLP]);
    assign windowed_watchdog_ev = rs.windowed_watchdog && wdt_run_now;
    assign windowed_watchdog_wake_idl = (state_reg == ST_IDLE) && windowed_watchdog_ev && !wake_irq;
    // A watchdog event in Idle is a wake, never a reset.
    assign rst_hit = rs.por
        || (rs.external_clear_pin && cfg_reg[CFG_XCLR])
        || (rs.brownout_reset && cfg_reg[CFG_BOR])
        || (rs.lowpower_brownout_reset && cfg_reg[CFG_LOWPOWER_BROWNOUT_RESET])
        || (windowed_watchdog_ev && (state_reg != ST_IDLE));
    assign ready_ok = i_program_flash_ready && i_sysclk_ready
        && (i_bor_ready || !cfg_reg[CFG_BOR]);
    assign cpu_go = q_end && in_run && doze_hit;
    // The vector is taken only on a CPU cycle after any multicycle instruction ends.
    assign take = isr_pend_reg && !i_core.multicycle_busy && cpu_go;
    assign slow_clr = wake_restores_speed && (take || irq_wake_idl);
    assign slow_set = exit_reslows && i_core.isr_return;
    assign wr_go = i_write && !wait_reg && i_byteenable[0];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (sleep_go) begin
                    state_next = ST_SLEEP;
                end else if (idle_go) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SLEEP: begin
                if (irq_wake_slp) begin
                    state_next = cfg_reg[CFG_XTAL] ? ST_OST : ST_READY;
                end
            end
            ST_IDLE: begin
                if (wake_irq || windowed_watchdog_ev) begin
                    state_next = ST_RUN;
                end
            end
            ST_OST: begin
                if (ost_reg == '0) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (ready_ok) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (rst_hit) begin
            state_next = ST_RUN;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Start-up delay counter; loaded on entry so the state lasts exactly OST_CYC cycles.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ost_reg <= '0;
        end else if (state_next == ST_OST && state_reg != ST_OST) begin
            ost_reg <= OST_W'(OST_CYC - 1);
        end else if (ost_reg != '0) begin
            ost_reg <= ost_reg - OST_W'(1);
        end
    end

    // Q phases advance whenever Fosc runs, so peripheral timing ignores doze.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            qph_reg <= '0;
        end else if (fosc_run) begin
            qph_reg <= qph_reg + 2'h1;
        end
    end

    // A new request in the same cycle as a take keeps the pending bit set.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            isr_pend_reg <= 1'b0;
        end else if (i_core.isr_request) begin
            isr_pend_reg <= 1'b1;
        end else if (take) begin
            isr_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pd_n_reg <= 1'b1;
            to_n_reg <= 1'b1;
        end else if (sleep_go) begin
            pd_n_reg <= 1'b0;
            to_n_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cause_reg <= CAUSE_NONE;
        end else if (irq_wake_slp || irq_wake_idl) begin
            cause_reg <= CAUSE_IRQ;
        end else if (windowed_watchdog_wake_idl) begin
            cause_reg <= CAUSE_WINDOWED_WATCHDOG;
        end else if (sleep_go || idle_go) begin
            cause_reg <= CAUSE_NONE;
        end
    end

    // Hardware set and clear of slow-CPU enable override a software write in the same cycle.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctl_reg <= CTL_RST;
        end else begin
            if (wr_go && i_address == DOZE_OFS) begin
                ctl_reg <= i_writedata[7:0] & CTL_MASK;
            end
            if (slow_clr) begin
                ctl_reg[CTL_SLOW] <= 1'b0;
            end
            if (slow_set) begin
                ctl_reg[CTL_SLOW] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cfg_reg <= CFG_RST;
        end else if (wr_go && i_address == CFG_OFS) begin
            cfg_reg <= i_writedata[7:0] & CFG_MASK;
        end
    end

    // Every request waits exactly one cycle; read data is latched before waitrequest drops.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wait_reg <= 1'b1;
            o_readdata <= '0;
        end else begin
            wait_reg <= !((i_read || i_write) && wait_reg);
            if (i_read && wait_reg) begin
                case (i_address)
                    DOZE_OFS: o_readdata <= {24'h000000, ctl_reg};
                    STAT_OFS: o_readdata <= {22'h000000, cause_reg, 1'b0, state_reg,
                        2'h0, to_n_reg, pd_n_reg};
                    CFG_OFS: o_readdata <= {24'h000000, cfg_reg};
                    default: o_readdata <= 32'h00000000;
                endcase
            end
        end
    end
    assign o_waitrequest = wait_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_cpu_cycle_en <= 1'b0;
            o_periph_q_en <= 1'b0;
            o_vector_fetch <= 1'b0;
            o_exec_prefetch <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_wdt_run <= 1'b0;
            o_device_reset <= 1'b0;
            o_cpu_clock_on <= 1'b1;
            o_fosc_on <= 1'b1;
            o_rc_osc_keep <= 1'b1;
            o_io_hold <= 1'b0;
        end else begin
            o_cpu_cycle_en <= cpu_go;
            o_periph_q_en <= q_end && fosc_run;
            o_vector_fetch <= take && !i_core.prefetch_clears_gate;
            o_exec_prefetch <= (state_reg == ST_READY && ready_ok && !rst_hit)
                || ((irq_wake_idl || windowed_watchdog_ev) && state_reg == ST_IDLE && !rst_hit);
            o_wdt_clear <= sleep_go || irq_wake_slp || state_reg == ST_OST;
            o_wdt_run <= wdt_run_now;
            o_device_reset <= rst_hit;
            o_cpu_clock_on <= (state_next == ST_RUN);
            o_fosc_on <= (state_next != ST_SLEEP) && (state_next != ST_OST);
            o_rc_osc_keep <= 1'b1;
            o_io_hold <= (state_next == ST_SLEEP) || (state_next == ST_OST);
        end
    end

    logic [OST_W:0] ost_seen;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || state_reg != ST_OST) begin
            ost_seen <= '0;
        end else begin
            ost_seen <= ost_seen + (OST_W+1)'(1);
        end
    end

    sleep_entry_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        sleep_go && !rst_hit |=> state_reg == ST_SLEEP && !pd_n_reg && to_n_reg
            && o_wdt_clear && !o_cpu_clock_on)
        else $error("Sleep entry did not update flags or clocks");
    sleep_nop_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        in_run && i_core.sleep_exec && sleep_nop && !rst_hit
            |=> state_reg == ST_RUN && $stable(pd_n_reg) && !o_wdt_clear)
        else $error("Sleep as no-operation changed state");
    idle_entry_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        idle_go && !rst_hit |=> state_reg == ST_IDLE && o_fosc_on && $stable(pd_n_reg))
        else $error("Idle entry wrong");
    irq_wake_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        irq_wake_slp && !rst_hit |=> (state_reg == ST_OST || state_reg == ST_READY)
            && o_wdt_clear && !o_device_reset)
        else $error("Interrupt wake from Sleep wrong");
    ost_length_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_reg == ST_READY && $past(state_reg) == ST_OST
            |-> $past(ost_seen) == (OST_W+1)'(OST_CYC - 1))
        else $error("Start-up delay length wrong");
    ready_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_reg == ST_READY && !ready_ok && !rst_hit |=> state_reg == ST_READY)
        else $error("Core released before ready");
    doze_gap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_cpu_cycle_en && slow_cpu_enable && ctl_reg[RATIO_W-1:0] == 3'h1
            |=> !o_cpu_cycle_en [*8])
        else $error("Doze 1:4 gap too short");
    periph_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_periph_q_en && fosc_run ##1 fosc_run [*3]) |=> o_periph_q_en)
        else $error("Peripheral Q rate broken");
    isr_speed_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        take && wake_restores_speed && !slow_set |=> !slow_cpu_enable)
        else $error("Service entry did not restore speed");
    reslow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        slow_set |=> slow_cpu_enable)
        else $error("Service exit did not reslow");
    windowed_watchdog_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        windowed_watchdog_wake_idl && !rst_hit |=> state_reg == ST_RUN && !o_device_reset
            && $stable(slow_cpu_enable) && $stable(halt_select))
        else $error("Watchdog in Idle misbehaved");

    cover_sleep_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) sleep_go);
    cover_nop_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        in_run && i_core.sleep_exec && sleep_nop);
    cover_ost_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        state_reg == ST_OST ##1 state_reg == ST_READY);
    cover_idle_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) irq_wake_idl);
endmodule

// ---- sim/pwrsv_ctrl_bench.sv ----
/*
 * Self-checking bench for the power-saving controller: register bus, doze ratios, ISR speed
 * changes, Sleep entry and wake, Idle, the external clear pin reset.
 * Assumes the controller alone, with the bench playing core, interrupt controller and pins.
 */
`timescale 1ns/10ps
module pwrsv_ctrl_bench;
    import pwrsv_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic [ADDR_W-1:0] i_address = '0;
    logic [31:0] i_writedata = '0, o_readdata;
    logic [3:0] i_byteenable = 4'h0;
    logic o_waitrequest, o_cpu_cycle_en, o_periph_q_en, o_vector_fetch, o_exec_prefetch;
    logic o_wdt_clear, o_device_reset, o_cpu_clock_on, o_fosc_on, o_io_hold, o_wdt_run;
    logic o_rc_osc_keep;
    logic rdy = 1'b1;
    pwrsv_core_t core = '0;
    pwrsv_rst_src_t pins = '0;
    logic [7:0] flags = 8'h00, ena = 8'h00;
    logic [31:0] expq[$], tmp;
    int n_fail = 0, comparisons = 0, seed = 74, per, hits;
    pwrsv_ctrl i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_core(core), .i_irq_flags(flags), .i_peripheral_irq_enable(ena), .i_rst_pins(pins),
        .i_program_flash_ready(rdy), .i_sysclk_ready(1'b1), .i_bor_ready(1'b1),
        .o_cpu_cycle_en(o_cpu_cycle_en), .o_periph_q_en(o_periph_q_en),
        .o_vector_fetch(o_vector_fetch), .o_exec_prefetch(o_exec_prefetch),
        .o_wdt_clear(o_wdt_clear), .o_wdt_run(o_wdt_run), .o_device_reset(o_device_reset),
        .o_cpu_clock_on(o_cpu_clock_on), .o_fosc_on(o_fosc_on), .o_rc_osc_keep(o_rc_osc_keep),
        .o_io_hold(o_io_hold));
    initial begin
        forever #2 i_clock = ~i_clock;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // A read notes its expected data; the monitor below compares when the answer comes.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int k;
        k = 0;
        if (!wr) expq.push_back({24'h000000, d});
        tmp = $random(seed);
        @(posedge i_clock);
        i_read <= !wr;
        i_write <= wr;
        i_address <= a;
        i_writedata <= wr ? {tmp[31:8], d} : 32'h00000000;
        i_byteenable <= {tmp[3:1], 1'b1};
        do begin
            @(posedge i_clock);
            k++;
        end while (o_waitrequest !== 1'b0);
        check("wait cycles", k, 2);
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    always @(posedge i_clock) begin
        if (i_read && o_waitrequest === 1'b0) check("readdata", o_readdata, expq.pop_front());
    end
    // Counts edges until a pulse is seen on the chosen output, bounded by lim.
    task automatic wait_for(input int sel, input int lim, output int n);
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (!((sel == 0 && o_cpu_cycle_en === 1'b1) ||
            (sel == 1 && o_periph_q_en === 1'b1) || (sel == 2 && o_vector_fetch === 1'b1) ||
            (sel == 3 && o_exec_prefetch === 1'b1) || (sel == 4 && o_device_reset === 1'b1))
            && n < lim);
    endtask
    task automatic pulse(input int which);
        @(posedge i_clock);
        core.sleep_exec <= (which == 0);
        core.isr_request <= (which == 1);
        core.isr_return <= (which == 2);
        @(posedge i_clock);
        core <= '{default: 1'b0, multicycle_busy: core.multicycle_busy,
            prefetch_clears_gate: core.prefetch_clears_gate, global_interrupt_gate: 1'b0};
    endtask
    initial begin
        repeat (60000) @(posedge i_clock);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        bus(0, DOZE_OFS, 8'h00);
        bus(0, CFG_OFS, 8'h0A);
        bus(0, STAT_OFS, 8'h03);
        bus(0, 12'h100, 8'h00);
        $display("test registers done");
        for (int r = 0; r < 8; r++) begin
            bus(1, DOZE_OFS, 8'h40 | r[7:0]);
            wait_for(0, 3000, per);
            wait_for(0, 3000, per);
            check("doze period", per, 4 * (2 << r));
        end
        wait_for(1, 20, per);
        wait_for(1, 20, per);
        check("q period", per, Q_PHASES);
        $display("test doze done");
        bus(1, DOZE_OFS, 8'h70);
        core.multicycle_busy <= 1'b1;
        pulse(1);
        wait_for(2, 20, per);
        check("vector early", per, 20);
        core.multicycle_busy <= 1'b0;
        wait_for(2, 200, per);
        check("vector late", per < 200, 1'b1);
        bus(0, DOZE_OFS, 8'h30);
        pulse(2);
        bus(0, DOZE_OFS, 8'h70);
        bus(1, DOZE_OFS, 8'h60);
        core.prefetch_clears_gate <= 1'b1;
        pulse(1);
        wait_for(2, 80, per);
        check("vector skipped", per, 80);
        core.prefetch_clears_gate <= 1'b0;
        bus(0, DOZE_OFS, 8'h20);
        $display("test isr done");
        bus(1, DOZE_OFS, 8'h00);
        flags <= 8'h02;
        ena <= 8'h02;
        pulse(0);
        repeat (3) @(posedge i_clock);
        check("nop sleep clock", o_cpu_clock_on, 1'b1);
        bus(0, STAT_OFS, 8'h03);
        flags <= 8'h0C;
        ena <= 8'h09;
        pulse(0);
        repeat (3) @(posedge i_clock);
        check("sleep clock", o_cpu_clock_on, 1'b0);
        check("sleep hold", o_io_hold, 1'b1);
        check("sleep rc osc", o_rc_osc_keep, 1'b1);
        check("sleep wdt off", o_wdt_run, 1'b0);
        bus(0, STAT_OFS, 8'h12);
        repeat (20) @(posedge i_clock);
        check("no wake", o_cpu_clock_on, 1'b0);
        flags <= 8'h0E;
        ena <= 8'h0B;
        hits = 0;
        for (per = 0; per < 40 && o_exec_prefetch !== 1'b1; per++) begin
            @(posedge i_clock);
            if (o_wdt_clear === 1'b1) hits++;
        end
        check("prefetch run", per < 40, 1'b1);
        check("wake wdt clear", hits > 0, 1'b1);
        repeat (2) @(posedge i_clock);
        check("awake clock", o_cpu_clock_on, 1'b1);
        flags <= 8'h00;
        // Crystal wake: the start-up delay runs, then the core waits for flash ready.
        bus(1, CFG_OFS, 8'h0B);
        pulse(0);
        flags <= 8'h02;
        rdy <= 1'b0;
        wait_for(3, 1100, per);
        check("ready hold", per, 1100);
        rdy <= 1'b1;
        wait_for(3, 10, per);
        check("ready release", per, 2);
        flags <= 8'h00;
        $display("test sleep done");
        bus(1, CFG_OFS, 8'h1A);
        bus(1, DOZE_OFS, 8'hE0);
        pulse(0);
        @(posedge i_clock);
        wait_for(0, 40, per);
        check("idle halted", per, 40);
        check("idle osc", o_fosc_on, 1'b1);
        check("idle wdt run", o_wdt_run, 1'b1);
        // The watchdog event is a one-cycle pulse; a held level would reset once awake.
        pins.windowed_watchdog <= 1'b1;
        @(posedge i_clock);
        pins.windowed_watchdog <= 1'b0;
        wait_for(0, 1000, per);
        check("windowed_watchdog wake", per < 1000, 1'b1);
        check("windowed_watchdog no reset", o_device_reset, 1'b0);
        bus(0, DOZE_OFS, 8'hE0);
        repeat (8) @(posedge i_clock);
        pulse(0);
        repeat (10) @(posedge i_clock);
        flags <= 8'h02;
        wait_for(0, 200, per);
        check("irq idle wake", per < 200, 1'b1);
        flags <= 8'h00;
        bus(0, DOZE_OFS, 8'hA0);
        $display("test idle done");
        pins.external_clear_pin <= 1'b1;
        wait_for(4, 10, per);
        check("clear pin reset", per < 10, 1'b1);
        pins.external_clear_pin <= 1'b0;
        repeat (8) @(posedge i_clock);
        check("reset released", o_device_reset, 1'b0);
        $display("test reset sources done");
        print_verdict();
    end
endmodule
